// ==== rtl/ulm_top.sv ====
// Serial port status block: line and modem status, scratch, port enable
// Notes on behaviour
// - Stop bit sampled low sets framing error
// - Line status read clears framing error
// - Fifo errors travel with character, shown at head
// - After framing error, faulty stop becomes start
// - Parity mismatch flagged; line status read clears
// - Single buffer: new character over unread one is dropped, sets overrun
// - Fifo overrun only when full, shown at once
// - Overrun character stays out of the fifo
// - Data ready while any received data unread
// - Line errors raise enabled line status interrupt
// - Four change bits, cleared by modem status read
// - Status bits 7..4 invert modem inputs
// - Loop mode mirrors aux two, aux one, DTR, RTS
// - Ring trailing edge only on rising ring pin
// - Any change bit raises modem status interrupt
// - Scratch byte read/write, no side effects
// - Port enable low stops port clock
// - Infrared duplex bit: half or forced full
// - Infrared loop-back bit enables loop-back test
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
module ulm_top
    import ulm_pkg::*;
(
    input  wire logic        clk,                 // System clock, 50 MHz
    input  wire logic        rst,                 // Async reset, active high
    input  wire logic        ce,                  // Clock enable, freezes all state when low
    input  wire logic        hsel,                // AHB slave select
    input  wire logic [31:0] haddr,               // AHB address
    input  wire logic [1:0]  htrans,              // AHB transfer type
    input  wire logic        hwrite,              // AHB write
    input  wire logic [2:0]  hsize,               // AHB size, word only
    input  wire logic [31:0] hwdata,              // AHB write data
    input  wire logic        hready,              // AHB bus ready
    output logic             hreadyout,           // AHB slave ready
    output logic             hresp,               // AHB response, always OKAY
    output logic [31:0]      hrdata,              // AHB read data
    input  wire logic        serial_in,           // Receive data pin
    input  wire logic        carrier_detect_in_n, // Carrier detect, active low
    input  wire logic        ring_in_n,           // Ring indicator, active low
    input  wire logic        data_set_ready_in_n, // Data set ready, active low
    input  wire logic        clear_to_send_in_n,  // Clear to send, active low
    output logic             dtr_out_n,           // Terminal ready, active low
    output logic             rts_out_n,           // Request to send, active low
    output logic             aux_output_one_n,    // First auxiliary output, active low
    output logic             aux_output_two_n,    // Second auxiliary output, active low
    output logic             port_clock_run,      // Port clock gate enable
    output logic             ir_mode,             // Infrared mode selected
    output logic             ir_full_duplex,      // Infrared forced full duplex
    output logic             ir_loopback,         // Infrared loop-back test on
    output logic             irq_line_status,     // Receiver line status interrupt
    output logic             irq_modem_status     // Modem status interrupt
);
    // Software registers
    logic [7:0] int_enable;          // Interrupt source enables
    logic [7:0] fifo_ctrl;           // Fifo mode control
    logic [7:0] line_ctrl;           // Parity format
    logic [7:0] modem_control_register; // Loop and modem outputs
    logic [7:0] temp_storage_register;  // Scratch byte
    logic [7:0] port_enable_register;   // Port and infrared enables

    // Receive path state
    ulm_char_t        fifo_mem [FIFO_DEPTH]; // Receive storage
    logic [PTR_W-1:0] wr_ptr;        // Write index
    logic [PTR_W-1:0] rd_ptr;        // Read index
    logic [PTR_W:0]   count;         // Characters held
    logic             overrun_flag;  // Sticky overrun
    logic             head_seen;     // Head errors already reported
    logic             rx_valid;      // Character completed
    ulm_char_t        rx_char;       // Completed character

    // Modem input state
    logic [3:0] modem_sync_a;        // First sync stage
    logic [3:0] modem_sync_b;        // Second sync stage
    logic [3:0] modem_prev;          // Previous effective status
    logic [3:0] modem_delta;         // Change bits

    // Bus state
    ulm_aphase_t aph;                // Captured address phase

    // Bus decode
    wire        take      = ce & hsel & hready & htrans[1];
    wire [7:0]  a_off     = haddr[7:0];
    wire        rd_take   = take & ~hwrite;
    wire        rd_lsr    = rd_take & (a_off == OFF_LINE_STATUS);
    wire        rd_msr    = rd_take & (a_off == OFF_MODEM_STATUS);
    wire        rd_rbr    = rd_take & (a_off == OFF_RX_DATA);
    wire        wr_now    = ce & aph.write;
    wire [7:0]  wbyte     = hwdata[7:0];

    // Fifo bookkeeping
    wire        fifo_mode = fifo_ctrl[FC_FIFO_EN];
    wire        empty     = (count == '0);
    wire        full      = fifo_mode ? (count == (PTR_W+1)'(FIFO_DEPTH)) : (count != '0);
    wire        push      = ce & rx_valid & ~full;
    wire        pop       = rd_rbr & ~empty;
    wire        overrun_ev = ce & rx_valid & full;
    wire ulm_char_t head  = fifo_mem[rd_ptr];

    // Head errors shown until reported
    wire        show_err  = ~empty & ~head_seen;
    wire        fe_bit    = show_err & head.framing_err;
    wire        pe_bit    = show_err & head.parity_err;
    wire [7:0]  line_status = {4'h0, fe_bit, pe_bit, overrun_flag, ~empty};

    // Modem status, true sense
    wire        loop_on   = modem_control_register[MC_LOOP];
    wire [3:0]  pin_true  = ~modem_sync_b;
    wire [3:0]  loop_true = {modem_control_register[MC_AUX2], modem_control_register[MC_AUX1],
                             modem_control_register[MC_DTR], modem_control_register[MC_RTS]};
    wire [3:0]  modem_now = loop_on ? loop_true : pin_true;
    wire [3:0]  delta_ev;            // Per-line change events
    wire [7:0]  modem_status = {modem_now, modem_delta};

    // Change events; ring only on the pin's rising edge
    assign delta_ev[3] = modem_now[3] ^ modem_prev[3];
    assign delta_ev[2] = modem_prev[2] & ~modem_now[2];
    assign delta_ev[1] = modem_now[1] ^ modem_prev[1];
    assign delta_ev[0] = modem_now[0] ^ modem_prev[0];

    // Read mux, values taken in the address phase
    wire [7:0] rd_value =
        (a_off == OFF_RX_DATA)      ? (empty ? 8'h00 : head.data) :
        (a_off == OFF_INT_ENABLE)   ? int_enable :
        (a_off == OFF_FIFO_CTRL)    ? fifo_ctrl :
        (a_off == OFF_LINE_CTRL)    ? line_ctrl :
        (a_off == OFF_MODEM_CTRL)   ? modem_control_register :
        (a_off == OFF_LINE_STATUS)  ? line_status :
        (a_off == OFF_MODEM_STATUS) ? modem_status :
        (a_off == OFF_SCRATCH)      ? temp_storage_register :
        (a_off == OFF_PORT_ENABLE)  ? port_enable_register :
                                      8'h00;

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Port and infrared controls straight from the enable register
    assign port_clock_run = port_enable_register[PE_PORT_ON];
    assign ir_mode        = port_enable_register[PE_IR_MODE];
    assign ir_full_duplex = port_enable_register[PE_IR_FULL];
    assign ir_loopback    = port_enable_register[PE_IR_LOOP];

    // Modem outputs held inactive in loop mode, as loop feeds status instead
    assign dtr_out_n        = ~(modem_control_register[MC_DTR] & ~loop_on);
    assign rts_out_n        = ~(modem_control_register[MC_RTS] & ~loop_on);
    assign aux_output_one_n = ~(modem_control_register[MC_AUX1] & ~loop_on);
    assign aux_output_two_n = ~(modem_control_register[MC_AUX2] & ~loop_on);

    // Interrupts follow the live status, so they drop as soon as software reads
    assign irq_line_status  = int_enable[IE_LINE_STATUS] & (overrun_flag | pe_bit | fe_bit);
    assign irq_modem_status = int_enable[IE_MODEM_STATUS] & (|modem_delta);

    // Receiver runs only while the port is enabled
    ulm_receiver u_rx (
        .clk        (clk),
        .rst        (rst),
        .run        (ce & port_clock_run),
        .serial_in  (serial_in),
        .parity_en  (line_ctrl[LC_PARITY_EN]),
        .even_sel   (line_ctrl[LC_EVEN_SEL]),
        .char_valid (rx_valid),
        .char_out   (rx_char)
    );

    // Address phase capture and registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aph    <= '0;
            hrdata <= '0;
        end else if (ce) begin
            aph.read   <= rd_take;
            aph.write  <= take & hwrite;
            aph.offset <= a_off;
            if (rd_take) hrdata <= {24'h0, rd_value};
        end
    end

    // Control register writes in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_enable             <= RESET_BYTE;
            fifo_ctrl              <= RESET_BYTE;
            line_ctrl              <= RESET_BYTE;
            modem_control_register <= RESET_BYTE;
            temp_storage_register  <= RESET_BYTE;
            port_enable_register   <= RESET_BYTE;
        end else if (wr_now) begin
            if (aph.offset == OFF_INT_ENABLE) int_enable <= wbyte;
            else if (aph.offset == OFF_FIFO_CTRL) fifo_ctrl <= wbyte;
            else if (aph.offset == OFF_LINE_CTRL) line_ctrl <= wbyte;
            else if (aph.offset == OFF_MODEM_CTRL) modem_control_register <= wbyte;
            else if (aph.offset == OFF_SCRATCH) temp_storage_register <= wbyte;
            else if (aph.offset == OFF_PORT_ENABLE) begin
                // Upper bits reserved, read zero
                port_enable_register <= wbyte & PE_WRITE_MASK;
            end
        end
    end

    // Receive storage, one slot per entry
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_slot
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                fifo_mem[i] <= '0;
            end else if (push && wr_ptr == PTR_W'(i)) begin
                fifo_mem[i] <= rx_char;
            end
        end
    end

    // Pointers and count; single-buffer mode wraps inside one slot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            if (push) wr_ptr <= fifo_mode ? wr_ptr + 1'b1 : rd_ptr;
            if (pop && fifo_mode) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // Overrun flag: a new overrun wins over a clearing read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_flag <= 1'b0;
        end else if (ce) begin
            if (overrun_ev) overrun_flag <= 1'b1;
            else if (rd_lsr) overrun_flag <= 1'b0;
        end
    end

    // Head errors reported once; a new head brings its own errors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_seen <= 1'b0;
        end else if (ce) begin
            if (pop || empty) head_seen <= 1'b0;
            else if (rd_lsr) head_seen <= 1'b1;
        end
    end

    // Modem pin synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modem_sync_a <= 4'hF;
            modem_sync_b <= 4'hF;
        end else if (ce) begin
            modem_sync_a <= {carrier_detect_in_n, ring_in_n,
                             data_set_ready_in_n, clear_to_send_in_n};
            modem_sync_b <= modem_sync_a;
        end
    end

    // Change bits: a change in the read cycle survives the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modem_prev  <= 4'h0;
            modem_delta <= 4'h0;
        end else if (ce) begin
            modem_prev  <= modem_now;
            modem_delta <= (rd_msr ? 4'h0 : modem_delta) | delta_ev;
        end
    end
endmodule : ulm_top

// ==== rtl/ulm_pkg.sv ====
// Register map, field positions and timing of the status block
package ulm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_RX_DATA      = 8'h00;
    localparam logic [7:0] OFF_INT_ENABLE   = 8'h04;
    localparam logic [7:0] OFF_FIFO_CTRL    = 8'h08;
    localparam logic [7:0] OFF_LINE_CTRL    = 8'h0C;
    localparam logic [7:0] OFF_MODEM_CTRL   = 8'h10;
    localparam logic [7:0] OFF_LINE_STATUS  = 8'h14;
    localparam logic [7:0] OFF_MODEM_STATUS = 8'h18;
    localparam logic [7:0] OFF_SCRATCH      = 8'h1C;
    localparam logic [7:0] OFF_PORT_ENABLE  = 8'h30;

    // Line status bit positions
    localparam int LS_DATA_READY = 0;
    localparam int LS_OVERRUN    = 1;
    localparam int LS_PARITY     = 2;
    localparam int LS_FRAMING    = 3;
    // Interrupt enable bit positions
    localparam int IE_LINE_STATUS  = 2;
    localparam int IE_MODEM_STATUS = 3;
    // Line control bit positions
    localparam int LC_PARITY_EN  = 3;
    localparam int LC_EVEN_SEL   = 4;
    // Fifo control bit position
    localparam int FC_FIFO_EN    = 0;
    // Modem control bit positions
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_AUX1 = 2;
    localparam int MC_AUX2 = 3;
    localparam int MC_LOOP = 4;
    // Port enable bit positions
    localparam int PE_PORT_ON  = 0;
    localparam int PE_IR_MODE  = 1;
    localparam int PE_IR_FULL  = 2;
    localparam int PE_IR_LOOP  = 3;
    localparam logic [7:0] PE_WRITE_MASK = 8'h0F;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Receive fifo geometry
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W      = 4;

    // Serial timing
    localparam int CLK_HZ     = 50_000_000;
    localparam int BAUD_RATE  = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int HALF_BIT   = BIT_CYCLES / 2;
    localparam int CNT_W      = 10;

    // Received character with its line errors
    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
        logic       framing_err;
    } ulm_char_t;

    // AHB address phase as captured by the slave
    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] offset;
    } ulm_aphase_t;
endpackage : ulm_pkg

// ==== rtl/ulm_receiver.sv ====
// Serial character receiver with parity check and framing-error resync
`timescale 1ns/1ns
module ulm_receiver
    import ulm_pkg::*;
(
    input  wire logic       clk,        // System clock
    input  wire logic       rst,        // Async reset, active high
    input  wire logic       run,        // Clock enable and port on
    input  wire logic       serial_in,  // Serial data pin, asynchronous
    input  wire logic       parity_en,  // Parity bit present
    input  wire logic       even_sel,   // Even parity when high
    output logic            char_valid, // One-cycle pulse per character
    output ulm_char_t       char_out    // Character and its errors
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ulm_rx_state_t;

    logic          sync_a;     // First synchroniser stage
    logic          sync_b;     // Second stage, the only one read
    ulm_rx_state_t state;      // Receiver state
    logic [CNT_W-1:0] cnt;     // Bit timer
    logic [2:0]    bit_idx;    // Data bit index
    logic [7:0]    shift;      // Data shift register
    logic          par_bad;    // Parity mismatch of this character

    wire tick         = (cnt == '0);
    wire parity_ok    = ^{shift, sync_b} ^ even_sel; // Odd total with odd select, even otherwise

    // Pin synchroniser, frozen with the port clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else if (run) begin
            sync_a <= serial_in;
            sync_b <= sync_a;
        end
    end

    // Character state machine, frozen while the port clock is stopped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= RX_IDLE;
            cnt        <= '0;
            bit_idx    <= '0;
            shift      <= '0;
            par_bad    <= 1'b0;
            char_valid <= 1'b0;
            char_out   <= '0;
        end else if (run) begin
            char_valid <= 1'b0;
            if (!tick) cnt <= cnt - 1'b1;
            case (state)
                RX_IDLE: begin
                    if (!sync_b) begin
                        state <= RX_START;
                        cnt   <= CNT_W'(HALF_BIT);
                    end
                end
                RX_START: begin
                    if (tick) begin
                        // A glitch shorter than half a bit is dropped
                        state   <= sync_b ? RX_IDLE : RX_DATA;
                        cnt     <= CNT_W'(BIT_CYCLES);
                        bit_idx <= '0;
                        par_bad <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        shift   <= {sync_b, shift[7:1]};
                        bit_idx <= bit_idx + 1'b1;
                        cnt     <= CNT_W'(BIT_CYCLES);
                        if (bit_idx == 3'd7) state <= parity_en ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY: begin
                    if (tick) begin
                        par_bad <= ~parity_ok;
                        cnt     <= CNT_W'(BIT_CYCLES);
                        state   <= RX_STOP;
                    end
                end
                default: begin
                    if (tick) begin
                        char_valid           <= 1'b1;
                        char_out.data        <= shift;
                        char_out.parity_err  <= par_bad;
                        char_out.framing_err <= ~sync_b;
                        if (!sync_b) begin
                            // Faulty stop taken as next start, sampled again then data
                            state <= RX_START;
                            cnt   <= CNT_W'(HALF_BIT);
                        end else begin
                            state <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule : ulm_receiver

// ==== verification/ulm_properties.sv ====
// Concurrent checks on the status block's ports
`timescale 1ns/1ns
module ulm_properties
    import ulm_pkg::*;
(
    input wire logic        clk,                // System clock
    input wire logic        rst,                // Async reset
    input wire logic        ce,                 // Clock enable
    input wire logic        hsel,               // AHB select
    input wire logic [31:0] haddr,              // AHB address
    input wire logic [1:0]  htrans,             // AHB transfer type
    input wire logic        hwrite,             // AHB write
    input wire logic [31:0] hwdata,             // AHB write data
    input wire logic        hreadyout,          // Slave ready, also bus ready
    input wire logic [31:0] hrdata,             // AHB read data
    input wire logic        clear_to_send_in_n, // Clear to send pin
    input wire logic        dtr_out_n,          // Terminal ready output
    input wire logic        port_clock_run,     // Port clock gate
    input wire logic        ir_loopback,        // Infrared loop-back
    input wire logic        irq_line_status,    // Line status interrupt
    input wire logic        irq_modem_status    // Modem status interrupt
);
    logic       aw;  // Write now in its data phase
    logic [7:0] ao;  // Offset of that write
    logic [7:0] mc;  // Shadow of modem control
    logic [7:0] scratch_storage; // Shadow of scratch
    logic [3:2] ie;  // Shadow of interrupt enables
    wire take = ce & hsel & hreadyout & htrans[1]; // Transfer accepted
    // Shadows land with the design's registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {aw, ao, mc, scratch_storage, ie} <= '0;
        end else if (ce) begin
            aw <= take & hwrite;
            ao <= haddr[7:0];
            if (aw && ao == OFF_MODEM_CTRL) mc <= hwdata[7:0];
            if (aw && ao == OFF_SCRATCH) scratch_storage <= hwdata[7:0];
            if (aw && ao == OFF_INT_ENABLE) ie <= hwdata[3:2];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write landing, read taken
    sequence s_wr(logic [7:0] o); aw && ce && ao == o; endsequence
    sequence s_rd(logic [7:0] o); take && !hwrite && haddr[7:0] == o; endsequence
    a_port_enable: assert property (s_wr(OFF_PORT_ENABLE)
        |=> port_clock_run == $past(hwdata[PE_PORT_ON])) else $error("port run wrong");
    a_ir_loop: assert property (s_wr(OFF_PORT_ENABLE)
        |=> ir_loopback == $past(hwdata[PE_IR_LOOP])) else $error("ir loop wrong");
    a_scratch_read: assert property (s_rd(OFF_SCRATCH)
        |=> hrdata == {24'h0, $past(scratch_storage)}) else $error("scratch read wrong");
    a_read_upper: assert property (take && !hwrite |=> hrdata[31:8] == '0)
        else $error("upper read bits set");
    a_dtr_loop: assert property (dtr_out_n == (mc[MC_LOOP] | ~mc[MC_DTR]))
        else $error("terminal ready output wrong");
    a_ls_gate: assert property (!ie[IE_LINE_STATUS] |-> !irq_line_status)
        else $error("line irq while disabled");
    a_ms_gate: assert property (!ie[IE_MODEM_STATUS] |-> !irq_modem_status)
        else $error("modem irq while disabled");
    a_cts_irq: assert property (ie[IE_MODEM_STATUS] && !mc[MC_LOOP] &&
        $changed(clear_to_send_in_n) |-> ##[1:4] irq_modem_status) else $error("no modem irq");
endmodule : ulm_properties

bind ulm_top ulm_properties u_props (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .clear_to_send_in_n(clear_to_send_in_n), .dtr_out_n(dtr_out_n),
    .port_clock_run(port_clock_run), .ir_loopback(ir_loopback),
    .irq_line_status(irq_line_status), .irq_modem_status(irq_modem_status)
);

// ==== verification/ulm_peer.sv ====
// Modem peer: serial line and control pins
`timescale 1ns/1ns
module ulm_peer
    import ulm_pkg::*;
(
    input  wire logic  clk,       // System clock, paces bit times
    output logic       serial_in, // Receive line, idles at mark
    output logic [3:0] modem_n    // Carrier, ring, dsr, cts, active low
);
    // Line idles high, modem pins inactive
    initial begin
        serial_in = 1'b1;
        modem_n   = 4'hF;
    end
    // Hold one level for some half bits
    task automatic hold_line(input logic v, input int halves);
        serial_in <= v;
        repeat (halves * HALF_BIT) @(posedge clk);
    endtask : hold_line
    // Start, eight data bits LSB first, even parity, stop
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        hold_line(1'b0, 2);
        for (int i = 0; i < 8; i++) hold_line(d[i], 2);
        hold_line(^d ^ bad_par, 2);
        // Low stop stretched to serve as next start
        hold_line(~bad_stop, bad_stop ? 3 : 2);
        if (bad_stop) serial_in <= 1'b1;
    endtask : send
    // New modem pin levels
    task automatic set_pins(input logic [3:0] v);
        modem_n <= v;
    endtask : set_pins
endmodule : ulm_peer

// ==== verification/testbench.sv ====
// Self-checking bench for the line and modem status block
`timescale 1ns/1ns
module testbench
    import ulm_pkg::*;
;
    logic        clk, rst, ce, hsel, hwrite, hreadyout, irq_ls, irq_ms, serial_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  modem_n;
    int          miscompares = 0;
    int          cmp_count = 0;
    ulm_peer peer (.clk(clk), .serial_in(serial_in), .modem_n(modem_n));
    ulm_top dut (
        .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .serial_in(serial_in),
        .carrier_detect_in_n(modem_n[3]), .ring_in_n(modem_n[2]),
        .data_set_ready_in_n(modem_n[1]), .clear_to_send_in_n(modem_n[0]),
        .dtr_out_n(), .rts_out_n(), .aux_output_one_n(), .aux_output_two_n(),
        .port_clock_run(), .ir_mode(), .ir_full_duplex(), .ir_loopback(),
        .irq_line_status(irq_ls), .irq_modem_status(irq_ms));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Counts, verdict, end of run
    task test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One AHB transfer, waits on ready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd_chk
    task ls(input logic [7:0] e);
        rd_chk(OFF_LINE_STATUS, {24'h0, e});
    endtask : ls
    task rx(input logic [7:0] e);
        rd_chk(OFF_RX_DATA, {24'h0, e});
    endtask : rx
    // Pins, then irq and status; the read clears
    task ms_step(input logic [3:0] pins, input logic [7:0] exp);
        peer.set_pins(pins);
        repeat (6) @(posedge clk);
        #1;
        chk({31'h0, irq_ms}, {31'h0, exp[3:0] != 4'h0});
        rd_chk(OFF_MODEM_STATUS, {24'h0, exp});
    endtask : ms_step
    task t_regs;
        wr(OFF_SCRATCH, 32'hA5);
        rd_chk(OFF_SCRATCH, 32'hA5);
        wr(OFF_PORT_ENABLE, 32'hFF);
        rd_chk(OFF_PORT_ENABLE, {24'h0, PE_WRITE_MASK});
        wr(8'h20, 32'h55);
        rd_chk(8'h20, 32'h0);
        wr(OFF_PORT_ENABLE, 32'h03);
        rd_chk(OFF_PORT_ENABLE, 32'h03);
    endtask : t_regs
    task t_modem;
        wr(OFF_INT_ENABLE, 32'h08);
        ms_step(4'hE, 8'h11);
        ms_step(4'hE, 8'h10);
        ms_step(4'hA, 8'h50);
        ms_step(4'hE, 8'h14);
        wr(OFF_MODEM_CTRL, 32'h1F);
        ms_step(4'hE, 8'hFA);
        wr(OFF_MODEM_CTRL, 32'h00);
        ms_step(4'hE, 8'h1E);
    endtask : t_modem
    // Single buffer, then fifo
    task t_rx;
        wr(OFF_PORT_ENABLE, 32'h01);
        wr(OFF_LINE_CTRL, 32'h18);
        wr(OFF_INT_ENABLE, 32'h04);
        peer.send(8'h5A, 1'b0, 1'b0);
        ls(8'h01);
        rx(8'h5A);
        ls(8'h00);
        peer.send(8'h3C, 1'b1, 1'b0);
        chk({31'h0, irq_ls}, 32'h1);
        ls(8'h05);
        ls(8'h01);
        rx(8'h3C);
        peer.send(8'hC3, 1'b0, 1'b1);
        ls(8'h09);
        ls(8'h01);
        rx(8'hC3);
        repeat (11 * BIT_CYCLES) @(posedge clk);
        ls(8'h05);
        rx(8'hFF);
        peer.send(8'h11, 1'b0, 1'b0);
        peer.send(8'h22, 1'b0, 1'b0);
        ls(8'h03);
        rx(8'h11);
        ls(8'h00);
        wr(OFF_FIFO_CTRL, 32'h01);
        peer.send(8'h44, 1'b0, 1'b0);
        peer.send(8'h55, 1'b1, 1'b0);
        ls(8'h01);
        rx(8'h44);
        ls(8'h05);
        rx(8'h55);
        ls(8'h00);
    endtask : t_rx
    initial begin
        rst = 1'b1;
        ce  = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_modem();
        t_rx();
        test_done();
    end
    // About 39k cycles of traffic; margin
    initial begin
        #1_500_000;
        miscompares++;
        test_done();
    end
endmodule : testbench
